/* logic/pmic_irq_pkg.sv */
// constants and carrier types for the interrupt mask block
// assumes a single 50 MHz clock and a byte-wide register port
package pmic_irq_pkg;

    localparam int data_width = 8;
    localparam int source_count = 6;

    // register subaddresses
    localparam logic [7:0] addr_event_flags = 8'h01;
    localparam logic [7:0] addr_loadswitch_event_flags = 8'h02;
    localparam logic [7:0] addr_interrupt_mask_one = 8'h03;

    // reset values
    localparam logic [7:0] interrupt_mask_one_reset = 8'h00;
    localparam logic [7:0] loadswitch_event_flags_reset = 8'h00;
    localparam logic [5:0] event_flags_reset = 6'h00;

    // writable bits of the mask register, bits 7:6 reserved
    localparam logic [7:0] interrupt_mask_one_writable = 8'h3f;

    // mask field positions, shared with the event source positions
    localparam int program_voltage_irq_mask = 5;
    localparam int mains_detect_irq_mask = 4;
    localparam int push_button_irq_mask = 3;
    localparam int overtemp_irq_mask = 2;
    localparam int coin_cell_acq_done_irq_mask = 1;
    localparam int program_done_irq_mask = 0;

    // load-switch flag positions
    localparam int switch2_current_limit_flag = 1;
    localparam int switch1_current_limit_flag = 0;

    // one register access, at most one of wr and rd per cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // event pulses from the six masked sources
    typedef struct packed {
        logic program_voltage;
        logic mains_detect_input;
        logic push_button_input;
        logic overtemp_warning;
        logic coin_cell_acq_done;
        logic program_done;
    } event_src_t;

    // live state of each load switch
    typedef struct packed {
        logic enabled;
        logic limiting;
    } switch_state_t;

endpackage

/* logic/event_latch.sv */
// sticky event flags, one per source, cleared as a group
// assumes set pulses and the clear are synchronous to clk_sys
module event_latch
    import pmic_irq_pkg::*;
#(
    parameter int width = source_count
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [width-1:0] set,
    input wire logic clear,
    output logic [width-1:0] flags
);

    // a set in the clearing cycle survives, so no event is lost
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            flags <= event_flags_reset[width-1:0];
        end
        else
        begin
            flags <= (clear ? '0 : flags) | set;
        end
    end

endmodule

/* logic/pmic_interrupt_mask_logic.sv */
// interrupt mask logic: event flags, load-switch limit flags, mask one
// assumes a host register port with one-cycle registered read answers
//
// Summary of operation
// - switch 2 limit flag, bit 1, is 1 while switch 2 limits current
// - switch 1 limit flag, bit 0, is 1 while switch 1 limits current
// - limit flags read 0 when disabled or not limiting; read-only, reset 0
// - mask register one sits at subaddress 0x03, resets to 0x00
// - an unmasked source event pulls the interrupt pin low
// - a masked source event leaves the interrupt pin alone
// - masks gate only the pin; event detection keeps running
// - bit 5 masks the programming-voltage source, read/write, reset 0
// - bit 4 masks the mains-detect source, read/write, reset 0
// - bit 3 masks the push-button source, read/write, reset 0
// - bit 2 masks the overtemperature source, read/write, reset 0
// - bit 1 masks coin-cell acquisition done, read/write, reset 0
// - bit 0 masks programming complete, read/write, reset 0
module pmic_interrupt_mask_logic
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire pmic_irq_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire pmic_irq_pkg::event_src_t events,
    input wire pmic_irq_pkg::switch_state_t switch1,
    input wire pmic_irq_pkg::switch_state_t switch2,
    output logic [5:0] event_flags,
    output logic irq_out_n
);
    import pmic_irq_pkg::*;

    logic [7:0] interrupt_mask_one;
    logic [7:0] loadswitch_event_flags;
    logic [5:0] flags;
    logic clear_events;
    logic [7:0] next_rdata;

    function automatic logic hit(input reg_req_t req, input logic [7:0] addr);
        hit = req.addr == addr;
    endfunction

    // reading the event register clears it; the read returns the old value
    assign clear_events = reg_req.rd && hit(reg_req, addr_event_flags);

    // detection never looks at the mask
    event_latch #(
        .width(source_count)
    ) u_events (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .set(events),
        .clear(clear_events),
        .flags(flags)
    );

    assign event_flags = flags;

    // mask register, reserved bits held at zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            interrupt_mask_one <= interrupt_mask_one_reset;
        end
        else if (reg_req.wr && hit(reg_req, addr_interrupt_mask_one))
        begin
            interrupt_mask_one <= reg_req.wdata & interrupt_mask_one_writable;
        end
    end

    // limit flags follow the switches live; no write path exists
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            loadswitch_event_flags <= loadswitch_event_flags_reset;
        end
        else
        begin
            loadswitch_event_flags <= '0;
            loadswitch_event_flags[switch2_current_limit_flag] <=
                switch2.enabled && switch2.limiting;
            loadswitch_event_flags[switch1_current_limit_flag] <=
                switch1.enabled && switch1.limiting;
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (hit(reg_req, addr_event_flags))
        begin
            next_rdata = {2'b00, flags};
        end
        else if (hit(reg_req, addr_loadswitch_event_flags))
        begin
            next_rdata = loadswitch_event_flags;
        end
        else if (hit(reg_req, addr_interrupt_mask_one))
        begin
            next_rdata = interrupt_mask_one;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // registered pin so it never glitches; costs one cycle after the flag
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            irq_out_n <= 1'b1;
        end
        else
        begin
            irq_out_n <= ~|(flags & ~interrupt_mask_one[5:0]);
        end
    end

    // helper: mask value as it was last cycle
    logic [5:0] mask_q;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mask_q <= 6'h00;
        end
        else
        begin
            mask_q <= interrupt_mask_one[5:0];
        end
    end

    a_limit_flag_two: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 loadswitch_event_flags[switch2_current_limit_flag]
            == $past(switch2.enabled && switch2.limiting))
        else $error("switch 2 limit flag wrong");

    a_limit_flag_one: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 loadswitch_event_flags[switch1_current_limit_flag]
            == $past(switch1.enabled && switch1.limiting))
        else $error("switch 1 limit flag wrong");

    a_limit_upper_zero: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        loadswitch_event_flags[7:2] == 6'h00)
        else $error("limit register upper bits set");

    a_mask_write_takes: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == addr_interrupt_mask_one
        |=> interrupt_mask_one
            == ($past(reg_req.wdata) & interrupt_mask_one_writable))
        else $error("mask write not stored");

    a_mask_holds: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !(reg_req.wr && reg_req.addr == addr_interrupt_mask_one)
        |=> $stable(interrupt_mask_one))
        else $error("mask changed without write");

    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        interrupt_mask_one[7:6] == 2'b00)
        else $error("reserved mask bits set");

    a_unmasked_pulls: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        events.push_button_input && !interrupt_mask_one[3] && !mask_q[3]
        ##1 !interrupt_mask_one[3] |=> !irq_out_n)
        else $error("unmasked event did not pull pin");

    a_masked_quiet: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (interrupt_mask_one[5:0] == 6'h3f) |=> irq_out_n)
        else $error("fully masked pin asserted");

    // unconditional on purpose: a masked event must still be recorded
    a_detect_ignores: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        events.overtemp_warning |=> flags[overtemp_irq_mask])
        else $error("event not recorded");

    a_pin_level: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 irq_out_n == !$past(|(flags & ~interrupt_mask_one[5:0])))
        else $error("pin does not match unmasked flags");

    a_read_answer: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        reg_req.rd && reg_req.addr == addr_interrupt_mask_one
        |=> reg_rvalid && reg_rdata == $past(interrupt_mask_one))
        else $error("mask readback wrong");

    c_pin_asserted: cover property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(irq_out_n));

    c_masked_event: cover property (@(posedge clk_sys) disable iff (sys_rst)
        events.mains_detect_input && interrupt_mask_one[4]);

    c_clear_release: cover property (@(posedge clk_sys) disable iff (sys_rst)
        clear_events ##2 $rose(irq_out_n));

    c_switch_limit: cover property (@(posedge clk_sys) disable iff (sys_rst)
        loadswitch_event_flags[1] && loadswitch_event_flags[0]);

endmodule

/* dv/host_irq_watch.sv */
// host side model: watches the active-low interrupt pin
// assumes the pin is driven by the block on clk_sys
module host_irq_watch
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic irq_out_n,
    output int irq_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_n;
    // counts each new assertion, so a pin stuck low counts only once
    always_ff @(posedge clk_sys)
    begin
        last_n <= sys_rst ? 1'b1 : irq_out_n;
        if (sys_rst)
            irq_count <= 0;
        else if (last_n && !irq_out_n)
            irq_count <= irq_count + 1;
    end
endmodule

/* dv/test_pmic_interrupt_mask_logic.sv */
// self-checking bench for the interrupt mask block
// assumes the package and design files are compiled first
module test_pmic_interrupt_mask_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import pmic_irq_pkg::*;
    logic clk_sys = 0;
    logic sys_rst = 1;
    reg_req_t reg_req = '0;
    event_src_t events = '0;
    switch_state_t switch1 = '0;
    switch_state_t switch2 = '0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [5:0] event_flags;
    logic irq_out_n;
    int irq_count;
    int n_mismatch = 0;
    int n_tests = 0;
    always #10 clk_sys = ~clk_sys;
    pmic_interrupt_mask_logic dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .events(events), .switch1(switch1), .switch2(switch2),
        .event_flags(event_flags), .irq_out_n(irq_out_n));
    host_irq_watch host_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .irq_out_n(irq_out_n), .irq_count(irq_count));
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        reg_req.wr = 1'b0;
    endtask
    // answer is fixed at one cycle after the read edge
    task reg_rd(input logic [7:0] a, input logic [7:0] exp, input string n);
        @(negedge clk_sys);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        reg_req.rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk(n, exp, reg_rdata);
    endtask
    task pulse(input int i);
        @(negedge clk_sys);
        events = event_src_t'(6'h01 << i);
        @(negedge clk_sys);
        events = '0;
    endtask
    task test_reset;
        reg_rd(addr_interrupt_mask_one, 8'h00, "mask");
        reg_rd(addr_loadswitch_event_flags, 8'h00, "limit");
        chk("irq", 8'h01, {7'h00, irq_out_n});
        $display("test_reset done");
    endtask
    task test_mask_rw;
        reg_wr(addr_interrupt_mask_one, 8'hff);
        reg_rd(addr_interrupt_mask_one, 8'h3f, "mask");
        reg_wr(addr_interrupt_mask_one, 8'h6a);
        reg_rd(addr_interrupt_mask_one, 8'h2a, "mask");
        reg_wr(addr_interrupt_mask_one, 8'h95);
        reg_rd(addr_interrupt_mask_one, 8'h15, "mask");
        reg_wr(8'h07, 8'h00);
        reg_rd(addr_interrupt_mask_one, 8'h15, "mask");
        reg_wr(addr_loadswitch_event_flags, 8'hff);
        reg_rd(addr_loadswitch_event_flags, 8'h00, "limit");
        $display("test_mask_rw done");
    endtask
    // each source once masked, once unmasked
    task test_sources;
        for (int i = 0; i < 6; i++)
        begin
            reg_wr(addr_interrupt_mask_one, 8'h01 << i);
            pulse(i);
            chk("flags", 8'h01 << i, {2'b00, event_flags});
            @(negedge clk_sys);
            chk("irq", 8'h01, {7'h00, irq_out_n});
            reg_rd(addr_event_flags, 8'h01 << i, "events");
            reg_wr(addr_interrupt_mask_one, 8'h00);
            pulse(i);
            @(negedge clk_sys);
            chk("irq", 8'h00, {7'h00, irq_out_n});
            reg_rd(addr_event_flags, 8'h01 << i, "events");
            @(negedge clk_sys);
            chk("irq", 8'h01, {7'h00, irq_out_n});
        end
        $display("test_sources done");
    endtask
    task test_switches;
        logic [3:0] k;
        for (int j = 0; j < 16; j++)
        begin
            k = 4'(j);
            @(negedge clk_sys);
            switch1 = k[1:0];
            switch2 = k[3:2];
            @(negedge clk_sys);
            reg_rd(addr_loadswitch_event_flags,
                {6'h00, k[3] & k[2], k[1] & k[0]}, "limit");
        end
        $display("test_switches done");
    endtask
    // an event landing in the clearing read must survive it
    task test_set_wins;
        reg_wr(addr_interrupt_mask_one, 8'h3f);
        @(negedge clk_sys);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr_event_flags, wdata: 8'h00};
        events = event_src_t'(6'h20);
        @(negedge clk_sys);
        reg_req.rd = 1'b0;
        events = '0;
        chk("events", 8'h00, reg_rdata);
        chk("flags", 8'h20, {2'b00, event_flags});
        @(negedge clk_sys);
        chk("irq", 8'h01, {7'h00, irq_out_n});
        reg_rd(addr_event_flags, 8'h20, "events");
        reg_wr(addr_interrupt_mask_one, 8'h00);
        $display("test_set_wins done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        test_reset();
        test_mask_rw();
        test_sources();
        test_set_wins();
        test_switches();
        chk("irq count", 8'h06, irq_count[7:0]);
        stop_test();
    end
    // whole run is under two hundred cycles; this allows ample margin
    initial
    begin
        #40000;
        n_mismatch++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
